// [pkg/ecit_pkg.sv]
// Constants for the edge capture and interval timer block
`default_nettype none
package ecit_pkg;
   // Bus and datapath widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;
   localparam int IVL_W  = 12;
   localparam int NCAP   = 4;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_C0R = 6'h22;
   localparam logic [5:0] IDX_C1R = 6'h23;
   localparam logic [5:0] IDX_C0F = 6'h24;
   localparam logic [5:0] IDX_C1F = 6'h25;
   localparam logic [5:0] IDX_IVL = 6'h26;
   localparam logic [5:0] IDX_IVH = 6'h27;
   localparam logic [5:0] IDX_RLL = 6'h28;
   localparam logic [5:0] IDX_RLH = 6'h29;
   localparam logic [5:0] IDX_CFG = 6'h2A;
   localparam logic [5:0] IDX_IEN = 6'h2B;
   localparam logic [5:0] IDX_STS = 6'h2C;

   // Configuration field positions
   localparam int CFG_KEEP   = 7;
   localparam int CFG_PRE_HI = 6;
   localparam int CFG_PRE_LO = 4;
   localparam int CFG_WIDE   = 3;

   // Writable bit masks and reset values
   localparam logic [7:0] CFG_WMASK = 8'hF8;
   localparam logic [7:0] NIB_WMASK = 8'h0F;
   localparam logic [7:0] RST_BYTE  = 8'h00;

   // Reference clock cycles per timebase tick
   localparam logic [7:0] TB_DIV = 8'h3E;
endpackage
`default_nettype wire

// [pkg/ecit_edge_if.sv]
// Edge pulses passed from the pin front end to the capture core
`timescale 1ns/1ps
`default_nettype none
interface ecit_edge_if;
   logic [1:0] rise;
   logic [1:0] fall;

   // Front end drives, core listens
   modport src (output rise, output fall);
   modport dst (input rise, input fall);
endinterface
`default_nettype wire

// [hdl/ecit_edge_det.sv]
// Pin synchronisers and edge detectors for both capture inputs
`timescale 1ns/1ps
`default_nettype none
module ecit_edge_det (
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [1:0] pins_i,
   ecit_edge_if.src        edges
);
   logic [1:0] meta_r;
   logic [1:0] sync_r;
   logic [1:0] prev_r;

   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_pin
         // Two-stage synchroniser, then one history stage
         always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               meta_r[p] <= 1'b0;
               sync_r[p] <= 1'b0;
               prev_r[p] <= 1'b0;
            end else begin
               meta_r[p] <= pins_i[p];
               sync_r[p] <= meta_r[p];
               prev_r[p] <= sync_r[p];
            end
         end

         // One-cycle edge pulses from synchronised level only
         assign edges.rise[p] = sync_r[p] & ~prev_r[p];
         assign edges.fall[p] = ~sync_r[p] & prev_r[p];
      end
   endgenerate
endmodule
`default_nettype wire

// [hdl/ecit_top.sv]
// Edge capture channels and interval timer with an APB register slave
//
// Notes on behaviour
// - Two 8-bit channels, each with rising and falling time registers.
// - Wide join bit ties channel 1 to pin 0; its registers hold the upper byte.
// - Each of four capture registers can request an interrupt on its edge.
// - Enable bits: 3 ch1 fall, 2 ch1 rise, 1 ch0 fall, 0 ch0 rise.
// - Keep bit clear: every edge overwrites, read gives latest edge.
// - Keep bit set: first edge held until that register is read.
// - Prescale field n selects counter bits n+7 down to n.
// - Pin 0 rise loads channel 0 rising; wide mode uses low byte.
// - Pin 0 fall loads channel 0 falling; wide mode uses low byte.
// - Channel 1 captures pin 1, or upper byte of pin 0 edges when wide.
// - Status bits: 3 ch1 fall, 2 ch1 rise, 1 ch0 fall, 0 ch0 rise.
// - Writing one clears a status bit; writing zero leaves it.
// - 12-bit interval count; low byte read latches upper nibble.
// - High register returns nibble latched at last low byte read.
// - 12-bit reload: low byte register plus nibble in next register.
// - Time base is a 16-bit free-running counter on the timebase tick.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ecit_top (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        edge_input_zero_i,
   input  wire logic        edge_input_one_i,
   output logic      [3:0]  capture_irq_o
);
   // Address hit on a register index, word aligned only
   function automatic logic reg_hit(input logic [7:0] a, input logic [5:0] idx);
      return (a[7:2] == idx) && (a[1:0] == 2'b00);
   endfunction

   // Prescaled byte of the counter
   function automatic logic [7:0] pre_byte(input logic [15:0] c, input logic [2:0] n);
      logic [15:0] s;
      s = c >> n;
      return s[7:0];
   endfunction

   logic [15:0] tb_cnt_r;
   logic [7:0]  tb_div_r;
   logic        tb_tick;
   logic [7:0]  cfg_r;
   logic [3:0]  ien_r;
   logic [3:0]  sts_r;
   logic [3:0]  sts_nxt;
   logic [7:0]  cap_r [4];
   logic [3:0]  full_r;
   logic [3:0]  cap_ev;
   logic [3:0]  cap_ld;
   logic [3:0]  cap_rd;
   logic [11:0] ivl_r;
   logic [3:0]  ivl_hold_r;
   logic [7:0]  rl_low_r;
   logic [11:0] reload_r;
   logic [7:0]  rd_mux;
   logic        map_ok;
   logic        setup;
   logic        acc;
   logic        wr_acc;
   logic        rd_acc;
   logic        keep;
   logic        wide;
   logic [2:0]  pre_n;

   ecit_edge_if edges ();

   // Pin front end
   ecit_edge_det i_ecit_edge_det (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .pins_i    ({edge_input_one_i, edge_input_zero_i}),
      .edges     (edges)
   );

   // Configuration fields
   assign keep  = cfg_r[ecit_pkg::CFG_KEEP];
   assign wide  = cfg_r[ecit_pkg::CFG_WIDE];
   assign pre_n = cfg_r[ecit_pkg::CFG_PRE_HI:ecit_pkg::CFG_PRE_LO];

   // Bus phases
   assign setup     = psel_i & ~penable_i;
   assign acc       = psel_i & penable_i;
   assign wr_acc    = acc & pwrite_i;
   assign rd_acc    = acc & ~pwrite_i;
   assign pready_o  = acc;
   assign pslverr_o = acc & ~map_ok;

   // Timebase tick divider
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tb_div_r <= 8'h00;
      end else if (tb_tick) begin
         tb_div_r <= 8'h00;
      end else begin
         tb_div_r <= tb_div_r + 8'h01;
      end
   end

   assign tb_tick = (tb_div_r == ecit_pkg::TB_DIV - 8'h01);

   // Free-running capture time base
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tb_cnt_r <= 16'h0000;
      end else if (tb_tick) begin
         tb_cnt_r <= tb_cnt_r + 16'h0001;
      end
   end

   // Configuration register, reserved bits stay zero
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_r <= ecit_pkg::RST_BYTE;
      end else if (wr_acc && reg_hit(paddr_i, ecit_pkg::IDX_CFG)) begin
         cfg_r <= pwdata_i[7:0] & ecit_pkg::CFG_WMASK;
      end
   end

   // Interrupt enable register
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ien_r <= 4'h0;
      end else if (wr_acc && reg_hit(paddr_i, ecit_pkg::IDX_IEN)) begin
         ien_r <= pwdata_i[3:0];
      end
   end

   // Capture registers: index 0 c0 rise, 1 c0 fall, 2 c1 rise, 3 c1 fall
   genvar k;
   generate
      for (k = 0; k < ecit_pkg::NCAP; k++) begin : g_cap
         localparam bit          FALL = (k % 2) == 1;
         localparam bit          CH1  = k >= 2;
         localparam logic [5:0]  IDX  = CH1 ? (FALL ? ecit_pkg::IDX_C1F : ecit_pkg::IDX_C1R)
                                            : (FALL ? ecit_pkg::IDX_C0F : ecit_pkg::IDX_C0R);
         logic [7:0] cap_data;

         // Edge source: channel 1 follows pin 0 when joined
         always_comb begin
            if (CH1 && !wide) begin
               cap_ev[k] = FALL ? edges.fall[1] : edges.rise[1];
            end else begin
               cap_ev[k] = FALL ? edges.fall[0] : edges.rise[0];
            end
         end

         // Captured byte selection
         always_comb begin
            if (wide) begin
               cap_data = CH1 ? tb_cnt_r[15:8] : tb_cnt_r[7:0];
            end else begin
               cap_data = pre_byte(tb_cnt_r, pre_n);
            end
         end

         // Load unless holding an unread first edge
         assign cap_ld[k] = cap_ev[k] & ~(keep & full_r[k]);
         assign cap_rd[k] = setup & ~pwrite_i & reg_hit(paddr_i, IDX); // data taken at setup

         // Time register
         always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               cap_r[k] <= ecit_pkg::RST_BYTE;
            end else if (cap_ld[k]) begin
               cap_r[k] <= cap_data;
            end
         end

         // Unread flag, a load wins over a read in the same cycle
         always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               full_r[k] <= 1'b0;
            end else if (cap_ld[k]) begin
               full_r[k] <= 1'b1;
            end else if (cap_rd[k]) begin
               full_r[k] <= 1'b0;
            end
         end
      end
   endgenerate

   // Status next value: edge set wins over write-one clear
   always_comb begin
      sts_nxt = sts_r;
      if (wr_acc && reg_hit(paddr_i, ecit_pkg::IDX_STS)) begin
         sts_nxt = sts_r & ~pwdata_i[3:0];
      end
      sts_nxt = sts_nxt | cap_ev;
   end

   // Status register
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sts_r <= 4'h0;
      end else begin
         sts_r <= sts_nxt;
      end
   end

   // Request lines
   assign capture_irq_o = sts_r & ien_r;

   // Interval counter runs down on the tick and reloads at zero
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ivl_r <= 12'h000;
      end else if (tb_tick) begin
         if (ivl_r == 12'h000) begin
            ivl_r <= reload_r;
         end else begin
            ivl_r <= ivl_r - 12'h001;
         end
      end
   end

   // Upper nibble snapshot on low byte read
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ivl_hold_r <= 4'h0;
      end else if (setup && !pwrite_i && reg_hit(paddr_i, ecit_pkg::IDX_IVL)) begin
         ivl_hold_r <= ivl_r[11:8];
      end
   end

   // Reload low byte staging
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rl_low_r <= ecit_pkg::RST_BYTE;
      end else if (wr_acc && reg_hit(paddr_i, ecit_pkg::IDX_RLL)) begin
         rl_low_r <= pwdata_i[7:0];
      end
   end

   // Reload value commits on the nibble write
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reload_r <= 12'h000;
      end else if (wr_acc && reg_hit(paddr_i, ecit_pkg::IDX_RLH)) begin
         reload_r <= {pwdata_i[3:0], rl_low_r};
      end
   end

   // Read multiplexer and map check
   always_comb begin
      rd_mux = 8'h00;
      map_ok = 1'b1;
      if (paddr_i[1:0] != 2'b00) begin
         map_ok = 1'b0;
      end else begin
         case (paddr_i[7:2])
            ecit_pkg::IDX_C0R: rd_mux = cap_r[0];
            ecit_pkg::IDX_C0F: rd_mux = cap_r[1];
            ecit_pkg::IDX_C1R: rd_mux = cap_r[2];
            ecit_pkg::IDX_C1F: rd_mux = cap_r[3];
            ecit_pkg::IDX_IVL: rd_mux = ivl_r[7:0];
            ecit_pkg::IDX_IVH: rd_mux = {4'h0, ivl_hold_r};
            ecit_pkg::IDX_RLL: rd_mux = rl_low_r;
            ecit_pkg::IDX_RLH: rd_mux = {4'h0, reload_r[11:8]};
            ecit_pkg::IDX_CFG: rd_mux = cfg_r;
            ecit_pkg::IDX_IEN: rd_mux = {4'h0, ien_r};
            ecit_pkg::IDX_STS: rd_mux = {4'h0, sts_r};
            default:           map_ok = 1'b0;
         endcase
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (setup) begin
         prdata_o <= {24'h00_0000, rd_mux};
      end
   end

   // Helper for the write-one clear check
   logic sts_wr;
   assign sts_wr = wr_acc && reg_hit(paddr_i, ecit_pkg::IDX_STS);

   // Edge always sets its status bit
   property p_sts_set;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      cap_ev[1] |=> sts_r[1];
   endproperty
   a_sts_set: assert property (p_sts_set) else $error("status not set on edge");

   // Write one clears when no edge competes
   property p_sts_clr;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      sts_wr && pwdata_i[2] && !cap_ev[2] |=> !sts_r[2];
   endproperty
   a_sts_clr: assert property (p_sts_clr) else $error("status not cleared");

   // Enabled edge raises its request next cycle
   property p_irq;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      cap_ev[3] && ien_r[3] && !(wr_acc && reg_hit(paddr_i, ecit_pkg::IDX_IEN))
      |=> capture_irq_o[3];
   endproperty
   a_irq: assert property (p_irq) else $error("request missing");

   // Held first edge is not overwritten
   property p_keep;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      keep && full_r[0] |=> $stable(cap_r[0]);
   endproperty
   a_keep: assert property (p_keep) else $error("held capture changed");

   // Overwrite mode takes the latest prescaled byte
   property p_pre;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !keep && !wide && cap_ev[0] |=> cap_r[0] == pre_byte($past(tb_cnt_r), $past(pre_n));
   endproperty
   a_pre: assert property (p_pre) else $error("prescaled capture wrong");

   // Joined mode puts the upper byte in channel 1
   property p_wide;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wide && !keep && cap_ev[3] |=> cap_r[3] == $past(tb_cnt_r[15:8]);
   endproperty
   a_wide: assert property (p_wide) else $error("upper byte not captured");

   // Low byte read freezes the upper nibble
   property p_latch;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      setup && !pwrite_i && reg_hit(paddr_i, ecit_pkg::IDX_IVL) |=> ivl_hold_r == $past(ivl_r[11:8]);
   endproperty
   a_latch: assert property (p_latch) else $error("nibble not latched");

   // Nibble write commits staged low byte
   property p_reload;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_acc && reg_hit(paddr_i, ecit_pkg::IDX_RLH)
      |=> reload_r == {$past(pwdata_i[3:0]), $past(rl_low_r)};
   endproperty
   a_reload: assert property (p_reload) else $error("reload not committed");

   // Counter advances once per tick
   property p_tb;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      tb_tick |=> tb_cnt_r == $past(tb_cnt_r) + 16'h0001 ##1 !tb_tick;
   endproperty
   a_tb: assert property (p_tb) else $error("time base did not advance");
endmodule
`default_nettype wire

// [test/ecit_pin_src.sv]
// Model of the external sources on the two capture pins
`timescale 1ns/1ps
`default_nettype none
module ecit_pin_src (
   input  wire logic clk_i,
   output var logic  pin0_o,
   output var logic  pin1_o
);
   // Both pins idle low and are always driven
   initial begin
      pin0_o = 1'b0;
      pin1_o = 1'b0;
   end

   // Level change after an edge, then held long enough for the synchroniser
   task automatic set_pin(input int idx, input logic lvl);
      @(posedge clk_i);
      if (idx == 0) begin
         pin0_o <= lvl;
      end else begin
         pin1_o <= lvl;
      end
      repeat (8) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// [test/ecit_tb_top.sv]
// Self-checking testbench for the capture and interval timer block
`timescale 1ns/1ps
`default_nettype none
module ecit_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pin0;
   logic        pin1;
   logic [3:0]  irq;
   int          num_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   logic [31:0] d;
   logic        e;
   int          t1;
   int          t2;
   logic [5:0]  cap_idx [4] = '{ecit_pkg::IDX_C0R, ecit_pkg::IDX_C0F,
                                ecit_pkg::IDX_C1R, ecit_pkg::IDX_C1F};

   ecit_top i_ecit_top (.ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .edge_input_zero_i(pin0),
      .edge_input_one_i(pin1), .capture_irq_o(irq));
   ecit_pin_src i_ecit_pin_src (.clk_i(clk), .pin0_o(pin0), .pin1_o(pin1));

   // 250 MHz clock
   always #2 clk = ~clk;

   // Cycles since reset release, and hang cut-off
   always @(posedge clk) begin
      cyc <= rst_n ? cyc + 1 : 0;
      if (cyc == 40000) begin
         num_errors++;
         complete_run();
      end
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // One APB transfer, waiting for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Only the global cycle limit ends a hang here
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // Captured byte may differ from the estimate by one count of that byte either way
   task automatic chk_near(input string nm, input int ex, input logic [31:0] got);
      logic [7:0] dd;
      dd = got[7:0] - ex[7:0];
      n_checks++;
      if (!(got[31:8] === 24'h0 && (dd === 8'h00 || dd === 8'hFF || dd === 8'h01))) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, ex[7:0], got);
      end
   endtask

   task automatic rdchk(input string nm, input logic [5:0] idx, input logic [31:0] ex);
      apb(1'b0, {idx, 2'b00}, 32'h0);
      chk(nm, ex, d);
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] v);
      apb(1'b1, {idx, 2'b00}, {24'h0, v});
   endtask

   task automatic pin(input int idx, input logic lvl, output int at);
      at = cyc + 1;
      i_ecit_pin_src.set_pin(idx, lvl);
   endtask

   // Expected counter byte at the capture moment
   function automatic int exv(input int at, input int n);
      return ((at + 4) / int'(ecit_pkg::TB_DIV)) >> n;
   endfunction

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values and refused addresses
      for (int i = 6'h22; i <= 6'h2C; i++) rdchk("reset", i[5:0], 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      apb(1'b0, 8'h89, 32'h0);
      chk("misaligned", 32'h1, {31'h0, e});
      $display("test reset done");
      // Writable masks of config and enable
      wr(ecit_pkg::IDX_CFG, 8'hFF);
      rdchk("cfg", ecit_pkg::IDX_CFG, 32'hF8);
      wr(ecit_pkg::IDX_IEN, 8'hFF);
      rdchk("ien", ecit_pkg::IDX_IEN, 32'h0F);
      wr(ecit_pkg::IDX_CFG, 8'h00);
      $display("test masks done");
      // Each edge kind loads its register and status bit
      for (int k = 0; k < 4; k++) begin
         pin(k >> 1, ~k[0], t1);
         rdchk("status", ecit_pkg::IDX_STS, (32'h2 << k) - 1);
         chk("irq", (32'h2 << k) - 1, {28'h0, irq});
         apb(1'b0, {cap_idx[k], 2'b00}, 32'h0);
         chk_near("capture", exv(t1, 0), d);
      end
      $display("test edges done");
      // Write-one-to-clear and irq gating
      wr(ecit_pkg::IDX_STS, 8'h00);
      rdchk("w0", ecit_pkg::IDX_STS, 32'h0F);
      wr(ecit_pkg::IDX_STS, 8'h05);
      rdchk("w1c", ecit_pkg::IDX_STS, 32'h0A);
      chk("irq_part", 32'hA, {28'h0, irq});
      wr(ecit_pkg::IDX_IEN, 8'h00);
      // Enable write lands at the access edge; look one edge later
      @(posedge clk);
      chk("irq_off", 32'h0, {28'h0, irq});
      rdchk("sticky", ecit_pkg::IDX_STS, 32'h0A);
      wr(ecit_pkg::IDX_STS, 8'h0A);
      wr(ecit_pkg::IDX_IEN, 8'h0F);
      $display("test clear done");
      // Prescale and latest-edge overwrite
      wr(ecit_pkg::IDX_CFG, 8'h30);
      pin(0, 1'b1, t1);
      pin(0, 1'b0, t1);
      repeat (600) @(posedge clk);
      pin(0, 1'b1, t1);
      apb(1'b0, {ecit_pkg::IDX_C0R, 2'b00}, 32'h0);
      chk("pre_err", 32'h0, {31'h0, e});
      chk_near("prescale", exv(t1, 3), d);
      pin(0, 1'b0, t2);
      $display("test prescale done");
      // First edge kept until read
      wr(ecit_pkg::IDX_CFG, 8'h80);
      repeat (300) @(posedge clk);
      pin(0, 1'b1, t1);
      pin(0, 1'b0, t2);
      repeat (300) @(posedge clk);
      pin(0, 1'b1, t2);
      apb(1'b0, {ecit_pkg::IDX_C0R, 2'b00}, 32'h0);
      chk_near("keep", exv(t1, 0), d);
      pin(0, 1'b0, t1);
      pin(0, 1'b1, t2);
      apb(1'b0, {ecit_pkg::IDX_C0R, 2'b00}, 32'h0);
      chk_near("reload_after_read", exv(t2, 0), d);
      pin(0, 1'b0, t1);
      $display("test keep done");
      // Wide join: pin one ignored, channel one holds upper byte
      wr(ecit_pkg::IDX_CFG, 8'h08);
      wr(ecit_pkg::IDX_STS, 8'h0F);
      pin(1, 1'b1, t1);
      rdchk("wide_pin1", ecit_pkg::IDX_STS, 32'h0);
      pin(0, 1'b1, t1);
      apb(1'b0, {ecit_pkg::IDX_C0R, 2'b00}, 32'h0);
      chk_near("wide_low", exv(t1, 0), d);
      apb(1'b0, {ecit_pkg::IDX_C1R, 2'b00}, 32'h0);
      chk_near("wide_high", exv(t1, 8), d);
      pin(0, 1'b0, t1);
      apb(1'b0, {ecit_pkg::IDX_C1F, 2'b00}, 32'h0);
      chk_near("wide_fall_high", exv(t1, 8), d);
      $display("test wide done");
      // Reload pair and interval readback
      wr(ecit_pkg::IDX_RLL, 8'h5A);
      wr(ecit_pkg::IDX_RLH, 8'hF3);
      rdchk("reload_low", ecit_pkg::IDX_RLL, 32'h5A);
      rdchk("reload_high", ecit_pkg::IDX_RLH, 32'h03);
      apb(1'b1, {ecit_pkg::IDX_IVL, 2'b00}, 32'hFF);
      chk("ro_write", 32'h0, {31'h0, e});
      // Let the count take the reload and run at most one tick
      repeat (70) @(posedge clk);
      apb(1'b0, {ecit_pkg::IDX_IVL, 2'b00}, 32'h0);
      chk_near("ivl_low", 32'h59, d);
      apb(1'b0, {ecit_pkg::IDX_IVH, 2'b00}, 32'h0);
      chk("ivh", 32'h03, d);
      $display("test interval done");
      complete_run();
   end
endmodule
`default_nettype wire
